/* include/fesc_defs.vh */
// constants for the flash erase/suspend host controller
// Function
// R01: chip erase is six writes: aa@555, 55@2aa, 80@555, aa@555, 55@2aa, 10@555
// R02: device preprograms and verifies array itself; host supplies no timing
// R03: after chip erase the bank returns to array read, addresses unlatched
// R04: during chip erase progress shows on toggle and polling status bits
// R05: commands during chip erase are ignored, suspend included; not suspendable
// R06: hardware reset aborts erase; host reissues sequence after array read
// R07: erase suspend is one write of b0 to the bank, only in sector erase
// R08: suspend takes effect within erase suspend latency, or at once in window
// R09: suspended bank enters suspend-read; unselected sectors readable, programmable
// R10: reads inside erase-suspended sectors return status on the low byte lines
// R11: program in erase suspend reports status normally, returns to suspend-read
// R12: identification query is accepted in erase-suspend-read state
// R13: erase resume is one write of 30 to the bank; repeats ignored
// R14: b0 during programming halts it within program suspend latency
// R15: reads of non-suspended sectors work during program suspend, also nested
// R16: identification query works in program suspend and exits back to it
// R17: program resume writes 30, address ignored; repeats ignored
// R18: after program resume device continues, status bits as normal program
// R19: host enters and exits the one-time area with its own sequences
// R20: polling bit reads 0 while erasing, 1 when done or erase-suspended
`ifndef FESC_DEFS_VH
`define FESC_DEFS_VH
`define FESC_ADDR_UNLOCK1 12'h555
`define FESC_ADDR_UNLOCK2 12'h2aa
`define FESC_DATA_UNLOCK1 16'h00aa
`define FESC_DATA_UNLOCK2 16'h0055
`define FESC_DATA_SETUP 16'h0080
`define FESC_DATA_CHIP_ERASE 16'h0010
`define FESC_DATA_SUSPEND 16'h00b0
`define FESC_DATA_RESUME 16'h0030
`define FESC_POLL_BIT 7
// apb register offsets
`define FESC_REG_CTRL 12'h000
`define FESC_REG_ADDR 12'h004
`define FESC_REG_DATA 12'h008
`define FESC_REG_STATUS 12'h00c
`define FESC_REG_RDATA 12'h010
// command codes in ctrl[2:0]
`define FESC_CMD_CHIP_ERASE 3'h1
`define FESC_CMD_SUSPEND 3'h2
`define FESC_CMD_RESUME 3'h3
`define FESC_CMD_WRITE 3'h4
`define FESC_CMD_READ 3'h5
`define FESC_CMD_POLL 3'h6
// bus cycle timing in pclk cycles
`define FESC_T_SETUP 4'h2
`define FESC_T_PULSE 4'h8
`define FESC_T_HOLD 4'h2
`endif

/* verilog/fesc_bus_cycle.v */
// one flash bus cycle (write or read) with setup, pulse and hold phases
`timescale 1ns/1ps
`default_nettype none
`include "fesc_defs.vh"
module fesc_bus_cycle #(
    parameter AW = 24,
    parameter DW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire cen,
    input wire start,
    input wire is_read,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output reg busy,
    output reg done,
    output reg [DW-1:0] rdata,
    output reg [AW-1:0] f_addr,
    output reg [DW-1:0] f_dq_out,
    output reg f_dq_oe_n,
    output reg f_ce_n,
    output reg f_we_n,
    output reg f_oe_n,
    input wire [DW-1:0] f_dq_in
);
    localparam P_IDLE = 2'h0;
    localparam P_SETUP = 2'h1;
    localparam P_PULSE = 2'h2;
    localparam P_HOLD = 2'h3;
    reg [1:0] phase;
    reg [3:0] cnt;
    reg rd;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= P_IDLE;
            cnt <= 4'h0;
            rd <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= {DW{1'b0}};
            f_addr <= {AW{1'b0}};
            f_dq_out <= {DW{1'b0}};
            f_dq_oe_n <= 1'b1;
            f_ce_n <= 1'b1;
            f_we_n <= 1'b1;
            f_oe_n <= 1'b1;
        end else if (cen) begin
            done <= 1'b0;
            case (phase)
                P_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        rd <= is_read;
                        f_addr <= addr;
                        f_dq_out <= wdata;
                        f_dq_oe_n <= is_read;
                        f_ce_n <= 1'b0;
                        cnt <= `FESC_T_SETUP;
                        phase <= P_SETUP;
                    end
                end
                P_SETUP: begin
                    if (cnt == 4'h1) begin
                        f_we_n <= rd;
                        f_oe_n <= ~rd;
                        cnt <= `FESC_T_PULSE;
                        phase <= P_PULSE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                P_PULSE: begin
                    if (cnt == 4'h1) begin
                        // the device latches write data on this rising edge
                        if (rd) begin
                            rdata <= f_dq_in;
                        end
                        f_we_n <= 1'b1;
                        f_oe_n <= 1'b1;
                        cnt <= `FESC_T_HOLD;
                        phase <= P_HOLD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                P_HOLD: begin
                    if (cnt == 4'h1) begin
                        f_ce_n <= 1'b1;
                        f_dq_oe_n <= 1'b1;
                        busy <= 1'b0;
                        done <= 1'b1;
                        phase <= P_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    phase <= P_IDLE;
                end
            endcase
        end
    end
endmodule // fesc_bus_cycle
`default_nettype wire

/* verilog/fesc_ctrl.v */
// apb-driven host sequencer for chip erase, suspend and resume of a nor flash
`timescale 1ns/1ps
`default_nettype none
`include "fesc_defs.vh"
module fesc_ctrl #(
    parameter AW = 24,
    parameter DW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire cen,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output wire [AW-1:0] f_addr,
    output wire [DW-1:0] f_dq_out,
    output wire f_dq_oe_n,
    input wire [DW-1:0] f_dq_in,
    output wire f_ce_n,
    output wire f_we_n,
    output wire f_oe_n,
    output reg f_reset_n
);
    localparam S_IDLE = 3'h0;
    localparam S_SEQ = 3'h1;
    localparam S_WAIT = 3'h2;
    localparam S_RST = 3'h3;
    reg [2:0] state;
    reg [2:0] step;
    reg [2:0] last_step;
    reg [2:0] cmd;
    reg [AW-1:0] addr_reg;
    reg [DW-1:0] data_reg;
    reg [DW-1:0] rd_reg;
    reg busy_flag;
    reg erase_done;
    reg chip_erasing;
    reg erase_susp;
    reg [3:0] rst_cnt;
    reg start;
    reg is_read;
    reg [AW-1:0] cyc_addr;
    reg [DW-1:0] cyc_data;
    wire cyc_done;
    wire [DW-1:0] cyc_rdata;
    wire acc = psel && penable && !pready;
    wire wr_ctrl = acc && pwrite && paddr == `FESC_REG_CTRL;
    // one step of the six-write chip erase sequence
    reg [11:0] seq_a;
    reg [DW-1:0] seq_d;
    always @* begin
        case (step)
            3'h0: begin
                seq_a = `FESC_ADDR_UNLOCK1;
                seq_d = `FESC_DATA_UNLOCK1;
            end
            3'h1: begin
                seq_a = `FESC_ADDR_UNLOCK2;
                seq_d = `FESC_DATA_UNLOCK2;
            end
            3'h2: begin
                seq_a = `FESC_ADDR_UNLOCK1;
                seq_d = `FESC_DATA_SETUP;
            end
            3'h3: begin
                seq_a = `FESC_ADDR_UNLOCK1;
                seq_d = `FESC_DATA_UNLOCK1;
            end
            3'h4: begin
                seq_a = `FESC_ADDR_UNLOCK2;
                seq_d = `FESC_DATA_UNLOCK2;
            end
            default: begin
                seq_a = `FESC_ADDR_UNLOCK1;
                seq_d = `FESC_DATA_CHIP_ERASE;
            end
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            state <= S_IDLE;
            step <= 3'h0;
            last_step <= 3'h0;
            cmd <= 3'h0;
            addr_reg <= {AW{1'b0}};
            data_reg <= {DW{1'b0}};
            rd_reg <= {DW{1'b0}};
            busy_flag <= 1'b0;
            erase_done <= 1'b0;
            chip_erasing <= 1'b0;
            erase_susp <= 1'b0;
            rst_cnt <= 4'h0;
            start <= 1'b0;
            is_read <= 1'b0;
            cyc_addr <= {AW{1'b0}};
            cyc_data <= {DW{1'b0}};
            f_reset_n <= 1'b0;
        end else if (cen) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            start <= 1'b0;
            if (acc) begin
                pready <= 1'b1;
                if (pwrite) begin
                    case (paddr)
                        `FESC_REG_CTRL: begin
                            // refused while a sequence is busy; cmd stays
                            // put so a refused write cannot derail it
                            if (!busy_flag) begin
                                cmd <= pwdata[2:0];
                            end
                            pslverr <= busy_flag;
                        end
                        `FESC_REG_ADDR: addr_reg <= pwdata[AW-1:0];
                        `FESC_REG_DATA: data_reg <= pwdata[DW-1:0];
                        `FESC_REG_STATUS: begin
                            // write one to clear; the poll set below is
                            // assigned later, so a same-cycle set wins
                            if (pwdata[1]) begin
                                erase_done <= 1'b0;
                            end
                        end
                        default: pslverr <= 1'b1;
                    endcase
                end else begin
                    case (paddr)
                        `FESC_REG_CTRL: prdata <= {29'h0, cmd};
                        `FESC_REG_ADDR: prdata <= {{(32-AW){1'b0}}, addr_reg};
                        `FESC_REG_DATA: prdata <= {{(32-DW){1'b0}}, data_reg};
                        `FESC_REG_STATUS: prdata <= {28'h0, erase_susp,
                            chip_erasing, erase_done, busy_flag};
                        `FESC_REG_RDATA: prdata <= {{(32-DW){1'b0}}, rd_reg};
                        default: begin
                            prdata <= 32'h0;
                            pslverr <= 1'b1;
                        end
                    endcase
                end
            end
            case (state)
                S_IDLE: begin
                    if (wr_ctrl && pwdata[3] && !busy_flag) begin
                        // reset aborts erase; software reissues the sequence
                        f_reset_n <= 1'b0; // [R06]
                        rst_cnt <= `FESC_T_PULSE;
                        chip_erasing <= 1'b0;
                        erase_susp <= 1'b0;
                        busy_flag <= 1'b1;
                        state <= S_RST;
                    end else if (wr_ctrl && !busy_flag) begin
                        f_reset_n <= 1'b1;
                        busy_flag <= 1'b1;
                        step <= 3'h0;
                        is_read <= 1'b0;
                        cyc_addr <= addr_reg;
                        cyc_data <= data_reg;
                        last_step <= 3'h0;
                        case (pwdata[2:0])
                            `FESC_CMD_CHIP_ERASE: begin
                                last_step <= 3'h5; // [R01]
                                erase_done <= 1'b0;
                            end
                            `FESC_CMD_SUSPEND:
                                cyc_data <= `FESC_DATA_SUSPEND; // [R07] [R14]
                            `FESC_CMD_RESUME:
                                cyc_data <= `FESC_DATA_RESUME; // [R13] [R17]
                            // one-time area entry and exit are plain writes
                            `FESC_CMD_WRITE: ; // [R19]
                            `FESC_CMD_READ: is_read <= 1'b1; // [R10]
                            `FESC_CMD_POLL: is_read <= 1'b1; // [R04]
                            default: ;
                        endcase
                        state <= S_SEQ;
                    end else begin
                        f_reset_n <= 1'b1;
                    end
                end
                S_SEQ: begin
                    if (cmd == `FESC_CMD_CHIP_ERASE) begin
                        cyc_addr <= {{(AW-12){1'b0}}, seq_a};
                        cyc_data <= seq_d;
                    end
                    start <= 1'b1;
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_done) begin
                        if (is_read) begin
                            rd_reg <= cyc_rdata;
                        end
                        if (step != last_step) begin
                            step <= step + 3'h1;
                            state <= S_SEQ;
                        end else begin
                            busy_flag <= 1'b0;
                            state <= S_IDLE;
                            case (cmd)
                                `FESC_CMD_CHIP_ERASE: chip_erasing <= 1'b1;
                                // suspend is meaningless during chip erase
                                `FESC_CMD_SUSPEND:
                                    erase_susp <= !chip_erasing; // [R05]
                                `FESC_CMD_RESUME: erase_susp <= 1'b0;
                                `FESC_CMD_POLL: begin
                                    // polling bit high ends the erase
                                    if (chip_erasing && cyc_rdata[`FESC_POLL_BIT])
                                    begin
                                        chip_erasing <= 1'b0; // [R20] [R03]
                                        erase_done <= 1'b1;
                                    end
                                end
                                default: ;
                            endcase
                        end
                    end
                end
                S_RST: begin
                    if (rst_cnt == 4'h1) begin
                        f_reset_n <= 1'b1;
                        busy_flag <= 1'b0;
                        state <= S_IDLE;
                    end else begin
                        rst_cnt <= rst_cnt - 4'h1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
    fesc_bus_cycle #(
        .AW(AW),
        .DW(DW)
    ) u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .cen(cen),
        .start(start),
        .is_read(is_read),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .busy(),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .f_addr(f_addr),
        .f_dq_out(f_dq_out),
        .f_dq_oe_n(f_dq_oe_n),
        .f_ce_n(f_ce_n),
        .f_we_n(f_we_n),
        .f_oe_n(f_oe_n),
        .f_dq_in(f_dq_in)
    );
endmodule // fesc_ctrl
`default_nettype wire

/* verif/fesc_ctrl_props.sv */
// port assertions for the flash erase/suspend host controller
`timescale 1ns/1ps
`default_nettype none
module fesc_ctrl_props #(
    parameter AW = 24,
    parameter DW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cen,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [AW-1:0] f_addr,
    input wire logic [DW-1:0] f_dq_out,
    input wire logic f_dq_oe_n,
    input wire logic [DW-1:0] f_dq_in,
    input wire logic f_ce_n,
    input wire logic f_we_n,
    input wire logic f_oe_n,
    input wire logic f_reset_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (
        psel && penable && !pready && cen |=> pready)
        else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    we_in_select_a: assert property (
        !f_we_n |-> !f_ce_n && !f_dq_oe_n)
        else $error("write strobe outside a driven select");
    strobe_excl_a: assert property (!(!f_we_n && !f_oe_n))
        else $error("read and write strobes together");
    we_width_a: assert property (
        $fell(f_we_n) |-> (!f_we_n)[*8] ##1 f_we_n)
        else $error("write pulse not eight cycles");
    data_hold_a: assert property (
        !f_we_n && !$past(f_we_n) |-> $stable(f_dq_out) && $stable(f_addr))
        else $error("address or data moved under write strobe");
    reset_pulse_a: assert property (
        $fell(f_reset_n) |-> (!f_reset_n)[*8])
        else $error("flash reset pulse too short");
    refused_c: cover property (pslverr);
    flash_reset_c: cover property ($fell(f_reset_n));
    flash_read_c: cover property ($fell(f_oe_n));
endmodule // fesc_ctrl_props
`default_nettype wire

/* verif/fesc_flash_model.sv */
// behavioural flash device answering erase, suspend and resume writes
`timescale 1ns/1ps
`default_nettype none
module fesc_flash_model #(
    parameter AW = 24,
    parameter DW = 16,
    parameter ERASE_NS = 3000,
    parameter PROG_NS = 2000
) (
    input wire logic [AW-1:0] f_addr,
    input wire logic [DW-1:0] f_dq_out,
    input wire logic f_ce_n,
    input wire logic f_we_n,
    input wire logic f_oe_n,
    input wire logic f_reset_n,
    output logic [DW-1:0] f_dq_in
);
    logic [2:0] step = 3'h0;
    logic chip_ers = 1'b0;
    logic sect_ers = 1'b0;
    logic susp = 1'b0;
    logic tog = 1'b0;
    logic pgm = 1'b0;
    logic psusp = 1'b0;
    logic pd7 = 1'b0;
    time p_end = 0;
    time p_left = 0;
    logic [DW-1:0] rd = 16'h0000;
    time t_end = 0;
    time t_left = 0;
    function automatic logic unlock_ok(input logic [2:0] s,
        input logic [11:0] a, input logic [15:0] d);
        case (s)
            0, 3: return a == 12'h555 && d == 16'h00aa;
            1, 4: return a == 12'h2aa && d == 16'h0055;
            2: return a == 12'h555 && d == 16'h0080;
            default: return 1'b0;
        endcase
    endfunction
    // erase runs on its own timer, the host only writes commands
    always @(posedge f_we_n or negedge f_reset_n) begin
        if (!f_reset_n) begin
            step = 3'h0;
            chip_ers = 1'b0;
            sect_ers = 1'b0;
            susp = 1'b0;
            pgm = 1'b0;
            psusp = 1'b0;
        end else if (!f_ce_n) begin
            if ($time >= p_end && !psusp) pgm = 1'b0;
            if ($time >= t_end) begin
                chip_ers = 1'b0;
                if (!susp) sect_ers = 1'b0;
            end
            if (chip_ers) begin
                step = 3'h0; // every write ignored, suspend too
            end else if (sect_ers && !susp && f_dq_out != 16'h00b0) begin
                step = 3'h0; // a running sector erase takes only suspend
            end else if (f_dq_out == 16'h0030 && psusp) begin
                psusp = 1'b0; // address ignored, repeats fall through
                p_end = $time + p_left;
            end else if (f_dq_out == 16'h00b0 && pgm && !psusp) begin
                psusp = 1'b1;
                p_left = p_end - $time;
            end else if (f_dq_out == 16'h00b0 && sect_ers && !susp) begin
                susp = 1'b1;
                t_left = t_end - $time;
            end else if (f_dq_out == 16'h0030 && susp) begin
                susp = 1'b0; // repeats fall through as noise
                t_end = $time + t_left;
            end else if (step == 6) begin
                pgm = 1'b1;
                pd7 = f_dq_out[7];
                p_end = $time + PROG_NS;
                step = 3'h0;
            end else if (step == 2 && f_dq_out == 16'h00a0) begin
                step = 3'h6;
            end else if (step == 5 && (f_dq_out == 16'h0030 ||
                f_dq_out == 16'h0010 && f_addr[11:0] == 12'h555)) begin
                chip_ers = !f_dq_out[5];
                sect_ers = f_dq_out[5];
                t_end = $time + ERASE_NS;
                step = 3'h0;
            end else if (unlock_ok(step, f_addr[11:0], f_dq_out))
                step = step + 3'h1;
            else
                step = 3'h0;
        end
    end
    always @(negedge f_oe_n) begin
        if (pgm && !psusp && $time < p_end) begin
            tog = ~tog;
            rd = {8'h00, ~pd7, tog, 6'h00};
        end else if ((chip_ers || sect_ers && !susp) && $time < t_end) begin
            tog = ~tog;
            rd = {9'h000, tog, 6'h00};
        end else if (susp)
            rd = 16'h0080;
        else
            rd = 16'hffff;
    end
    // a released bus shows the inverse so stale data cannot pass
    assign f_dq_in = (!f_ce_n && !f_oe_n) ? rd : ~rd;
endmodule // fesc_flash_model
`default_nettype wire

/* verif/flash_erase_suspend_control_bench.sv */
// self-checking bench for the flash erase/suspend host controller
`timescale 1ns/1ps
`default_nettype none
`include "fesc_defs.vh"
module flash_erase_suspend_control_bench;
    localparam AW = 24;
    localparam DW = 16;
    logic pclk, presetn, psel, penable, pwrite, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, f_dq_oe_n, f_ce_n, f_we_n, f_oe_n, f_reset_n;
    wire [AW-1:0] f_addr;
    wire [DW-1:0] f_dq_out, f_dq_in;
    int fail_count = 0;
    int checked = 0;
    fesc_ctrl #(.AW(AW), .DW(DW)) DUT (.pclk(pclk), .presetn(presetn),
        .cen(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .f_addr(f_addr), .f_dq_out(f_dq_out),
        .f_dq_oe_n(f_dq_oe_n), .f_dq_in(f_dq_in), .f_ce_n(f_ce_n),
        .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_reset_n(f_reset_n));
    fesc_flash_model #(.AW(AW), .DW(DW)) flash (.f_addr(f_addr),
        .f_dq_out(f_dq_out), .f_ce_n(f_ce_n), .f_we_n(f_we_n),
        .f_oe_n(f_oe_n), .f_reset_n(f_reset_n), .f_dq_in(f_dq_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) chk(0, 1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `FESC_REG_STATUS, 0);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        if (n >= 100) chk(0, 1);
    endtask
    task automatic cmd(input logic [31:0] c);
        apb(1'b1, `FESC_REG_CTRL, c);
        wait_idle;
    endtask
    task automatic t_regs;
        apb(1'b0, `FESC_REG_STATUS, 0);
        chk(q, 0);
        apb(1'b0, 12'h020, 0);
        chk(e, 1);
        chk(q, 0);
        $display("test regs done");
    endtask
    task automatic t_chip;
        int n;
        apb(1'b1, `FESC_REG_CTRL, `FESC_CMD_CHIP_ERASE);
        apb(1'b1, `FESC_REG_CTRL, `FESC_CMD_RESUME);
        chk(e, 1); // busy controller refuses a command
        wait_idle;
        chk(flash.chip_ers, 1);
        chk(q[3:1], 3'b010);
        apb(1'b1, `FESC_REG_ADDR, 32'h1000);
        cmd(`FESC_CMD_SUSPEND);
        chk({flash.susp, q[3]}, 2'b00);
        cmd(`FESC_CMD_POLL);
        apb(1'b0, `FESC_REG_RDATA, 0);
        chk(q[7], 0);
        n = 0;
        do begin
            cmd(`FESC_CMD_POLL);
            n++;
        end while (q[1] !== 1'b1 && n < 60);
        chk(q[3:1], 3'b001);
        apb(1'b1, `FESC_REG_STATUS, 32'h2);
        apb(1'b0, `FESC_REG_STATUS, 0);
        chk(q, 0);
        $display("test chip erase done");
    endtask
    task automatic t_susp;
        logic [11:0] ta [6] = '{12'h555, 12'h2aa, 12'h555, 12'h555,
            12'h2aa, 12'h100};
        logic [15:0] td [6] = '{16'h00aa, 16'h0055, 16'h0080, 16'h00aa,
            16'h0055, 16'h0030};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `FESC_REG_ADDR, {20'h00000, ta[i]});
            apb(1'b1, `FESC_REG_DATA, {16'h0000, td[i]});
            cmd(`FESC_CMD_WRITE);
        end
        chk(flash.sect_ers, 1);
        cmd(`FESC_CMD_SUSPEND);
        chk({flash.susp, q[3]}, 2'b11);
        cmd(`FESC_CMD_READ);
        apb(1'b0, `FESC_REG_RDATA, 0);
        chk(q, 32'h80);
        cmd(`FESC_CMD_RESUME);
        chk({flash.susp, q[3]}, 2'b00);
        cmd(`FESC_CMD_RESUME);
        cmd(`FESC_CMD_POLL);
        apb(1'b0, `FESC_REG_RDATA, 0);
        chk({flash.sect_ers, q[7]}, 2'b10);
        $display("test suspend done");
    endtask
    task automatic t_reset;
        int n;
        n = 0;
        // the resumed sector erase must finish before a new command counts
        do begin
            cmd(`FESC_CMD_POLL);
            apb(1'b0, `FESC_REG_RDATA, 0);
            n++;
        end while (q[7] !== 1'b1 && n < 60);
        chk(q[7], 1);
        cmd(`FESC_CMD_CHIP_ERASE);
        chk(flash.chip_ers, 1);
        cmd(32'h8);
        chk({flash.chip_ers, q[2]}, 2'b00);
        cmd(`FESC_CMD_READ);
        apb(1'b0, `FESC_REG_RDATA, 0);
        chk(q, 32'hffff);
        $display("test reset done");
    endtask
    task automatic fw(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, `FESC_REG_ADDR, {20'h00000, a});
        apb(1'b1, `FESC_REG_DATA, {16'h0000, d});
        cmd(`FESC_CMD_WRITE);
    endtask
    task automatic t_prog;
        fw(12'h555, 16'h00aa);
        fw(12'h2aa, 16'h0055);
        fw(12'h555, 16'h00a0);
        fw(12'h200, 16'h00c3);
        chk(flash.pgm, 1);
        cmd(`FESC_CMD_SUSPEND);
        chk(flash.psusp, 1);
        apb(1'b1, `FESC_REG_ADDR, 32'h4000);
        cmd(`FESC_CMD_READ);
        apb(1'b0, `FESC_REG_RDATA, 0);
        chk(q, 32'hffff);
        cmd(`FESC_CMD_RESUME);
        cmd(`FESC_CMD_RESUME);
        chk({flash.pgm, flash.psusp}, 2'b10);
        apb(1'b1, `FESC_REG_ADDR, 32'h200);
        cmd(`FESC_CMD_POLL);
        apb(1'b0, `FESC_REG_RDATA, 0);
        chk(q[7], 0);
        $display("test program suspend done");
    endtask
    task automatic give_verdict;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #200000;
        fail_count++;
        give_verdict;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_chip;
        t_susp;
        t_reset;
        t_prog;
        give_verdict;
    end
endmodule // flash_erase_suspend_control_bench
bind fesc_ctrl fesc_ctrl_props #(.AW(AW), .DW(DW)) u_props (.pclk(pclk),
    .presetn(presetn), .cen(cen), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .f_addr(f_addr),
    .f_dq_out(f_dq_out), .f_dq_oe_n(f_dq_oe_n), .f_dq_in(f_dq_in),
    .f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n),
    .f_reset_n(f_reset_n));
`default_nettype wire
